// [rtl/fwup_pkg.sv]
/* fwup_pkg: command codes, status layout, log geometry and timing
   constants shared by the upgrade and event log command handler.
   Assumes a single 200 MHz clock domain. */
package fwup_pkg;
  localparam logic [7:0]  CMD_UNLOCK   = 8'hE0;
  localparam logic [7:0]  CMD_STATUS   = 8'hE5;
  localparam logic [7:0]  CMD_BOOT     = 8'hE6;
  localparam logic [7:0]  CMD_XFER     = 8'hE7;
  localparam logic [7:0]  CMD_LOG      = 8'hF0;
  localparam logic [7:0]  BOOT_ENTER   = 8'h01;
  localparam logic [7:0]  BOOT_ERASE   = 8'h02;
  localparam logic [7:0]  BOOT_DONE    = 8'h03;
  localparam logic [7:0]  BOOT_EXIT    = 8'h04;
  localparam logic [7:0]  TGT_SEC      = 8'h73; // 's'
  localparam logic [7:0]  TGT_IFC      = 8'h69; // 'i'
  localparam logic [7:0]  UNLOCK_LEN   = 8'h04;
  localparam logic [31:0] UNLOCK_WORD  = 32'h55504744; // "UPGD"
  localparam logic [15:0] SEQ_FIRST    = 16'h0000;
  localparam logic [7:0]  XFER_RD_CNT  = 8'h03;
  localparam logic [7:0]  ST_ERASED_OK = 8'h81;
  localparam logic [7:0]  ST_BOOT_OK   = 8'h80;
  localparam logic [7:0]  ST_APP       = 8'h00;
  localparam logic [7:0]  ST_DS_MASK   = 8'hBF;
  localparam logic [15:0] CRC16_POLY   = 16'h1021;
  localparam logic [15:0] CRC16_INIT   = 16'hFFFF;
  localparam logic [7:0]  PEC_POLY     = 8'h07;
  localparam logic [15:0] IMG_MAX_DEF  = 16'hFFFF;
  localparam int          LOG_RECORDS  = 5;
  localparam logic [2:0]  LOG_LAST_REC = 3'h4;
  localparam logic [10:0] LOG_USED     = 11'h028; // 5 records of 8 bytes
  localparam logic [7:0]  LOG_LEN_MAX  = 8'h20;
  localparam logic [10:0] LOG_STEP     = 11'h020; // 0000h..07E0h, wraps
  localparam int          CLK_NS       = 5;
  localparam int          TS_TICK_MS   = 1;
  localparam int          TS_TICK_CYC  = TS_TICK_MS * 1000000 / CLK_NS;

  typedef struct packed {
    logic in_boot;
    logic downstr;
    logic rsv1;
    logic rsv0;
    logic addr_err;
    logic seq_err;
    logic crc_err;
    logic erased;
  } status_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_RX   = 6'b000100,
    ST_ACK  = 6'b001000,
    ST_TX   = 6'b010000,
    ST_MACK = 6'b100000
  } bus_t;
endpackage

// [rtl/fwup_ctrl.sv]
/* fwup_ctrl: SMBus target for firmware upgrade and event log upload.
   Assumes open-drain SDA resolved outside, DEV_ADDR static, LOG_* and
   SEC_DATA_OK driven from the CLK domain. */
// Notes on behaviour
// - Command E6 runs enter, erase, done, exit.
// - Data 1 enter, 2 erase, 3 done, 4 exit.
// - Target byte ignored for enter and exit.
// - Main output forced off inside boot block.
// - Status after erase reads 0x81.
// - Packets use E7, first sequence 0x0000.
// - Read returns count 3, sequence, status, PEC.
// - Done checks CRC-16 against last two bytes.
// - Passing check gives status 0x80.
// - Exit only when every image valid.
// - After exit status reads 0x00.
// - Never start application after errors.
// - Five rolling records, oldest overwritten.
// - Log read: length up to 32, data, PEC.
// - Missing secondary data gives length zero.
// - 2048-byte log read in 32-byte chunks.
// - Upgrade commands locked until password accepted.
// - Status flag bits as defined layout.
// - Target byte p, s or i.
`timescale 1ns/1ps
module fwup_ctrl #(
  parameter int          TICK_CYC = fwup_pkg::TS_TICK_CYC, // cycles per ms
  parameter logic [15:0] IMG_MAX  = fwup_pkg::IMG_MAX_DEF, // image bytes
  parameter logic [2:0]  TGT_HAVE = 3'h7,                  // i,s,p present
  parameter bit          DOWNSTR  = 1'b0                   // downstream flag
) (
  input  wire logic         CLK,         // 200 MHz clock
  input  wire logic         RESET_N,     // synchronous reset
  input  wire logic [6:0]   DEV_ADDR,    // bus target address
  input  wire logic         SCL_IN,      // bus clock pin
  input  wire logic         SDA_IN,      // bus data pin
  output logic              SDA_OUT,     // data drive level, low
  output logic              SDA_OE,      // pulls data line low
  input  wire logic         LOG_TRIG,    // record trigger pulse
  input  wire logic [31:0]  LOG_SNAP,    // snapshot contents
  input  wire logic         SEC_DATA_OK, // secondary data gathered
  output logic              MAIN_OFF,    // main output forced off
  output logic              UNLOCKED,    // upgrade commands enabled
  output fwup_pkg::status_t STATUS       // loader status byte
);
  import fwup_pkg::*;

  function automatic logic [7:0] pec_step(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ PEC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ CRC16_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // unknown characters fall back to the primary processor
  function automatic logic [1:0] tgt_idx(input logic [7:0] t);
    case (t)
      TGT_SEC: return 2'h1;
      TGT_IFC: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction

  logic [1:0]  scl_q, sda_q;
  logic        scl_p, sda_p, scl, sda, rise, fall, start_c, stop_c;
  bus_t        st_r;
  logic [2:0]  bit_r;
  logic [7:0]  sh_r, tx_r, tx_next, rx_byte, pec_r, idx_r;
  logic        rw_r, busy_r, rx_done, tx_load, wr_b, pec_ok;
  logic [5:0]  tidx_r;
  logic [7:0]  cmd_r, arg_r, dat_r;
  logic [31:0] pw_r;
  logic [15:0] seq_r, crc_r, hold_r, cnt_r, crc_s, hold_s, cnt_s;
  logic [1:0]  nhold_r, nhold_s, tgt;
  logic        pkt_ok_r, seq_bad_r, unl_r, e6_go, xdat, xpec, allv;
  logic [2:0]  valid_r;
  status_t     status_r;
  logic [63:0] rec_r [LOG_RECORDS];
  logic [2:0]  wptr_r, ri;
  logic [31:0] ts_r, tick_r;
  logic [10:0] chunk_r, laddr;
  logic [7:0]  len_r, log_len, lbyte;

  // pins cross in two flops; edges are read from the second stage only
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= {scl_q[0], SCL_IN};
      sda_q <= {sda_q[0], SDA_IN};
      scl_p <= scl_q[1];
      sda_p <= sda_q[1];
    end
  end

  assign scl     = scl_q[1];
  assign sda     = sda_q[1];
  assign rise    = scl & ~scl_p;
  assign fall    = ~scl & scl_p;
  assign start_c = scl & scl_p & sda_p & ~sda;
  assign stop_c  = scl & scl_p & ~sda_p & sda;
  assign rx_byte = {sh_r[6:0], sda};
  assign rx_done = rise & (st_r == ST_ADDR || st_r == ST_RX) &
                   (bit_r == 3'h7);
  assign tx_load = fall & ((st_r == ST_ACK && SDA_OE && rw_r) ||
                           st_r == ST_MACK);
  assign SDA_OUT = 1'b0;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_r   <= ST_IDLE;
      bit_r  <= 3'h0;
      sh_r   <= 8'h00;
      rw_r   <= 1'b0;
      tx_r   <= 8'h00;
      SDA_OE <= 1'b0;
    end else if (start_c) begin
      st_r   <= ST_ADDR;
      bit_r  <= 3'h0;
      SDA_OE <= 1'b0;
    end else if (stop_c) begin
      st_r   <= ST_IDLE;
      SDA_OE <= 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_RX: if (rise) begin
          sh_r  <= rx_byte;
          bit_r <= bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            if (st_r == ST_ADDR) rw_r <= sda;
            st_r <= (st_r == ST_RX || rx_byte[7:1] == DEV_ADDR) ?
                    ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: if (fall) begin
          if (!SDA_OE) begin
            SDA_OE <= 1'b1;
          end else if (rw_r) begin
            st_r   <= ST_TX;
            tx_r   <= tx_next;
            SDA_OE <= ~tx_next[7];
          end else begin
            st_r   <= ST_RX;
            SDA_OE <= 1'b0;
          end
        end
        ST_TX: begin
          if (rise) bit_r <= bit_r + 3'h1;
          if (fall && bit_r == 3'h0) begin
            SDA_OE <= 1'b0;
            st_r   <= ST_MACK;
          end else if (fall) begin
            SDA_OE <= ~tx_r[3'h7 - bit_r];
          end
        end
        ST_MACK: if (rise && sda) begin
          st_r <= ST_IDLE; // host not-acknowledge ends the read
        end else if (fall) begin
          st_r   <= ST_TX;
          tx_r   <= tx_next;
          SDA_OE <= ~tx_next[7];
        end
        default: ;
      endcase
    end
  end

  // PEC spans the whole transaction, repeated start included
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      busy_r <= 1'b0;
      pec_r  <= 8'h00;
      idx_r  <= 8'h00;
      tidx_r <= 6'h00;
    end else if (start_c) begin
      tidx_r <= 6'h00;
      busy_r <= 1'b1;
      if (!busy_r) begin
        pec_r <= 8'h00;
        idx_r <= 8'h00;
      end
    end else if (stop_c) begin
      busy_r <= 1'b0;
    end else if (rx_done) begin
      pec_r <= pec_step(pec_r, rx_byte);
      if (st_r == ST_RX) idx_r <= idx_r + 8'h01;
    end else if (tx_load) begin
      pec_r  <= pec_step(pec_r, tx_next);
      tidx_r <= tidx_r + 6'h01;
    end
  end

  assign wr_b   = rx_done & (st_r == ST_RX);
  assign pec_ok = (rx_byte == pec_r);
  assign tgt    = tgt_idx(arg_r);
  assign e6_go  = wr_b & (cmd_r == CMD_BOOT) & (idx_r == 8'h03) & pec_ok &
                  unl_r;
  assign xdat   = wr_b & (cmd_r == CMD_XFER) & (idx_r >= 8'h04) &
                  (idx_r <= arg_r + 8'h01);
  assign xpec   = wr_b & (cmd_r == CMD_XFER) & (idx_r == arg_r + 8'h02);
  assign allv   = &(valid_r | ~TGT_HAVE);
  assign STATUS   = status_r;
  assign UNLOCKED = unl_r;
  assign MAIN_OFF = status_r.in_boot;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cmd_r     <= 8'h00;
      arg_r     <= 8'h00;
      dat_r     <= 8'h00;
      pw_r      <= 32'h0;
      unl_r     <= 1'b0;
      seq_r     <= SEQ_FIRST;
      crc_r     <= CRC16_INIT;
      hold_r    <= 16'h0;
      nhold_r   <= 2'h0;
      cnt_r     <= 16'h0;
      crc_s     <= CRC16_INIT;
      hold_s    <= 16'h0;
      nhold_s   <= 2'h0;
      cnt_s     <= 16'h0;
      pkt_ok_r  <= 1'b0;
      seq_bad_r <= 1'b0;
      valid_r   <= 3'h7;
      status_r  <= '0;
      status_r.downstr <= DOWNSTR;
    end else if (wr_b) begin
      case (idx_r)
        8'h00: cmd_r <= rx_byte;
        8'h01: arg_r <= rx_byte;
        8'h02: dat_r <= rx_byte;
        default: ;
      endcase
      if (cmd_r == CMD_UNLOCK && idx_r >= 8'h02 && idx_r <= 8'h05)
        pw_r <= {pw_r[23:0], rx_byte};
      if (cmd_r == CMD_UNLOCK && idx_r == 8'h06 && pec_ok)
        unl_r <= (arg_r == UNLOCK_LEN) && (pw_r == UNLOCK_WORD);
      // packet state is snapshotted so a refused packet leaves sum, held bytes and count as they were
      if (idx_r == 8'h00 && rx_byte == CMD_XFER) begin
        crc_s     <= crc_r;
        hold_s    <= hold_r;
        nhold_s   <= nhold_r;
        cnt_s     <= cnt_r;
        pkt_ok_r  <= unl_r & status_r.in_boot & status_r.erased;
        seq_bad_r <= 1'b0;
      end
      if (cmd_r == CMD_XFER && idx_r == 8'h03 && {rx_byte, dat_r} != seq_r)
        seq_bad_r <= 1'b1;
      if (xdat && pkt_ok_r && !seq_bad_r && !status_r.addr_err) begin
        if (cnt_r >= IMG_MAX) begin
          status_r.addr_err <= 1'b1;
        end else begin
          // last two bytes stay out of the sum: they are the check value
          cnt_r  <= cnt_r + 16'h0001;
          hold_r <= {rx_byte, hold_r[15:8]};
          if (nhold_r == 2'h2) crc_r <= crc_step(crc_r, hold_r[7:0]);
          else nhold_r <= nhold_r + 2'h1;
        end
      end
      if (xpec) begin
        if (pkt_ok_r && !seq_bad_r && pec_ok && !status_r.addr_err) begin
          seq_r <= seq_r + 16'h0001;
        end else begin
          crc_r   <= crc_s;
          hold_r  <= hold_s;
          nhold_r <= nhold_s;
          cnt_r   <= cnt_s;
          if (pkt_ok_r) status_r.seq_err <= 1'b1;
        end
      end
      if (e6_go) begin
        case (dat_r)
          BOOT_ENTER: status_r.in_boot <= 1'b1;
          BOOT_ERASE: if (status_r.in_boot) begin
            status_r.erased   <= 1'b1;
            status_r.crc_err  <= 1'b0;
            status_r.seq_err  <= 1'b0;
            status_r.addr_err <= 1'b0;
            seq_r   <= SEQ_FIRST;
            crc_r   <= CRC16_INIT;
            nhold_r <= 2'h0;
            cnt_r   <= 16'h0;
            valid_r[tgt] <= 1'b0;
          end
          BOOT_DONE: if (status_r.in_boot) begin
            if (status_r.erased && nhold_r == 2'h2 && crc_r == hold_r &&
                !status_r.seq_err && !status_r.addr_err) begin
              status_r.erased  <= 1'b0;
              status_r.crc_err <= 1'b0;
              valid_r[tgt]     <= 1'b1;
            end else begin
              status_r.crc_err <= 1'b1;
            end
          end
          BOOT_EXIT: if (allv && !status_r.crc_err && !status_r.seq_err &&
                         !status_r.addr_err)
            status_r.in_boot <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // millisecond time stamp from a one-cycle tick enable
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tick_r <= 32'h0;
      ts_r   <= 32'h0;
    end else if (tick_r == 32'(TICK_CYC - 1)) begin
      tick_r <= 32'h0;
      ts_r   <= ts_r + 32'h1;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wptr_r <= 3'h0;
      for (int i = 0; i < LOG_RECORDS; i++) rec_r[i] <= 64'h0;
    end else if (LOG_TRIG) begin
      rec_r[wptr_r] <= {ts_r, LOG_SNAP};
      wptr_r <= (wptr_r == LOG_LAST_REC) ? 3'h0 : wptr_r + 3'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      chunk_r <= 11'h000;
      len_r   <= 8'h00;
    end else if (tx_load && cmd_r == CMD_LOG) begin
      if (tidx_r == 6'h00) len_r <= log_len;
      else if (len_r != 8'h00 && tidx_r == len_r[5:0] + 6'h01)
        chunk_r <= chunk_r + LOG_STEP;
    end
  end

  assign log_len = SEC_DATA_OK ? LOG_LEN_MAX : 8'h00;
  assign laddr   = chunk_r + {5'h00, tidx_r} - 11'h001;
  assign ri      = (laddr < LOG_USED) ? laddr[5:3] : 3'h0;
  assign lbyte   = (laddr < LOG_USED) ?
                   8'(rec_r[ri] >> {laddr[2:0], 3'h0}) : 8'h00;

  always_comb begin
    tx_next = 8'hFF;
    case (cmd_r)
      CMD_STATUS: tx_next = (tidx_r == 6'h00) ? status_r : pec_r;
      CMD_XFER: case (tidx_r)
        6'h00:   tx_next = XFER_RD_CNT;
        6'h01:   tx_next = seq_r[7:0];
        6'h02:   tx_next = seq_r[15:8];
        6'h03:   tx_next = status_r;
        default: tx_next = pec_r;
      endcase
      CMD_LOG: begin
        if (tidx_r == 6'h00) tx_next = log_len;
        else if ({2'h0, tidx_r} <= len_r) tx_next = lbyte;
        else tx_next = pec_r;
      end
      default: ;
    endcase
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_boot(logic [7:0] op);
    e6_go && dat_r == op;
  endsequence

  property p_xfer_count;
    tx_load && cmd_r == CMD_XFER && tidx_r == 6'h00 |=> tx_r == XFER_RD_CNT;
  endproperty
  a_xfer_count: assert property (p_xfer_count)
    else $error("transfer read count not 3");
  property p_erase_status;
    s_boot(BOOT_ERASE) ##0 status_r.in_boot |=>
      (8'(status_r) & ST_DS_MASK) == ST_ERASED_OK;
  endproperty
  a_erase_status: assert property (p_erase_status)
    else $error("status after erase wrong");
  property p_done_status;
    s_boot(BOOT_DONE) ##0 (status_r.in_boot && crc_r == hold_r &&
      (8'(status_r) & ST_DS_MASK) == ST_ERASED_OK && nhold_r == 2'h2) |=>
      (8'(status_r) & ST_DS_MASK) == ST_BOOT_OK;
  endproperty
  a_done_status: assert property (p_done_status)
    else $error("status after passing check wrong");
  // checks the enter decode itself, not only the output wiring
  property p_main_off;
    s_boot(BOOT_ENTER) |=> MAIN_OFF;
  endproperty
  a_main_off: assert property (p_main_off)
    else $error("main output on in boot block");
  property p_exit_stays;
    s_boot(BOOT_EXIT) ##0 (status_r.crc_err || !allv) |=> status_r.in_boot;
  endproperty
  a_exit_stays: assert property (p_exit_stays)
    else $error("application started despite errors");
  property p_exit_app;
    s_boot(BOOT_EXIT) ##0 (allv && (8'(status_r) & ST_DS_MASK) == ST_BOOT_OK)
      |=> (8'(status_r) & ST_DS_MASK) == ST_APP [*2];
  endproperty
  a_exit_app: assert property (p_exit_app)
    else $error("status after exit not zero");
  property p_locked;
    $rose(status_r.in_boot) |-> $past(unl_r);
  endproperty
  a_locked: assert property (p_locked)
    else $error("boot entered while locked");
  property p_bad_pkt;
    xpec && (seq_bad_r || !pec_ok) |=> $stable(seq_r) && crc_r == $past(crc_s);
  endproperty
  a_bad_pkt: assert property (p_bad_pkt)
    else $error("bad packet changed loader state");
  property p_log_len;
    tx_load && cmd_r == CMD_LOG && tidx_r == 6'h00 |=> tx_r <= LOG_LEN_MAX;
  endproperty
  a_log_len: assert property (p_log_len)
    else $error("log length above 32");
  property p_chunk;
    chunk_r[4:0] == 5'h00 && wptr_r <= LOG_LAST_REC;
  endproperty
  a_chunk: assert property (p_chunk)
    else $error("log chunk or record pointer out of range");
endmodule // fwup_ctrl

// [verif/smbus_host.sv]
/* smbus_host: behavioural host controller on the upgrade bus.
   Assumes a pull-up resolves SDA outside and clk is the 200 MHz clock. */
`timescale 1ns/1ps
module smbus_host #(
  parameter logic [6:0] ADDR = 7'h2A, // target address
  parameter int         GAP  = 40     // shortened host waits, cycles
) (
  input  wire logic clk,     // bench clock
  input  wire logic sda_in,  // resolved data line
  output logic      scl,     // bus clock, idles high
  output logic      sda_low  // host pulls data low
);
  logic [7:0] pec;
  logic [7:0] rd [40];
  logic       nack_seen;

  initial begin
    scl       = 1'b1;
    sda_low   = 1'b0;
    nack_seen = 1'b0;
  end

  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction

  // quarter of an 80 ns bus bit, always just after a clock edge
  task automatic q;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic bitx(input logic o, output logic i);
    sda_low = ~o;
    q;
    scl = 1'b1;
    q;
    i = sda_in;
    q;
    scl = 1'b0;
    q;
  endtask

  task automatic start;
    sda_low = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask

  task automatic stop;
    sda_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b0;
    q;
  endtask

  task automatic wbyte(input logic [7:0] b);
    logic a;
    for (int k = 7; k >= 0; k--) bitx(b[k], a);
    bitx(1'b1, a);
    if (a) nack_seen = 1'b1;
    pec = crc8(pec, b);
  endtask

  task automatic rbyte(input logic last, output logic [7:0] b);
    logic a;
    for (int k = 7; k >= 0; k--) bitx(1'b1, b[k]);
    bitx(last, a);
    pec = crc8(pec, b);
  endtask

  // nr: bytes before PEC, 0 means length-prefixed block
  task automatic xfer(input int nw, input logic [7:0] w [8],
                      input logic rd_en, input int nr);
    int n;
    pec       = 8'h00;
    nack_seen = 1'b0;
    start;
    wbyte({ADDR, 1'b0});
    for (int k = 0; k < nw; k++) wbyte(w[k]);
    if (!rd_en) wbyte(pec);
    else begin
      repeat (GAP) @(posedge clk);
      #1;
      start;
      wbyte({ADDR, 1'b1});
      rbyte(1'b0, rd[0]);
      n = (nr > 0) ? nr : int'(rd[0]) + 1;
      if (n > 38) n = 38;
      for (int k = 1; k < n; k++) rbyte(1'b0, rd[k]);
      rbyte(1'b1, rd[n]);
    end
    stop;
  endtask

  // busy time after erase, done and exit, shortened
  task automatic hold_off;
    repeat (GAP) @(posedge clk);
    #1;
  endtask
endmodule // smbus_host

// [verif/tb_top.sv]
/* tb_top: scenario bench for the upgrade and event log handler.
   Assumes fwup_pkg, fwup_ctrl and smbus_host are compiled first. */
`timescale 1ns/1ps
module tb_top;
  import fwup_pkg::*;
  logic        CLK;
  logic        RESET_N;
  logic        LOG_TRIG;
  logic        SEC_DATA_OK;
  logic [31:0] LOG_SNAP;
  logic        scl;
  logic        sda_low;
  logic        sda_oe;
  logic        sda_out;
  logic        main_off;
  logic        unlocked;
  status_t     st;
  wire         sda = ~sda_low & (~sda_oe | sda_out); // pull-up
  int          fails;
  int          compares;
  logic [7:0]  w [8];
  logic [15:0] ck;

  fwup_ctrl #(.TICK_CYC(4)) i_dut (
    .CLK(CLK), .RESET_N(RESET_N), .DEV_ADDR(7'h2A), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .LOG_TRIG(LOG_TRIG),
    .LOG_SNAP(LOG_SNAP), .SEC_DATA_OK(SEC_DATA_OK), .MAIN_OFF(main_off),
    .UNLOCKED(unlocked), .STATUS(st));
  smbus_host #(.ADDR(7'h2A)) i_host (
    .clk(CLK), .sda_in(sda), .scl(scl), .sda_low(sda_low));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    c = CRC16_INIT;
    for (int k = 47; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? CRC16_POLY : 16'h0000);
    return c;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input int nw);
    i_host.xfer(nw, w, 1'b0, 0);
    chk8({7'h00, i_host.nack_seen}, 8'h00);
  endtask

  task automatic boot(input logic [7:0] tgt, input logic [7:0] op);
    w[0] = CMD_BOOT;
    w[1] = tgt;
    w[2] = op;
    wr(3);
    i_host.hold_off();
  endtask

  task automatic stat(input logic [7:0] exp);
    w[0] = CMD_STATUS;
    w[1] = 8'h70; // primary
    i_host.xfer(2, w, 1'b1, 1);
    chk8(i_host.rd[0], exp);
    chk8(i_host.pec, 8'h00);
    chk8(st, exp);
  endtask

  task automatic rd_seq(input logic [15:0] sq, input logic [7:0] s);
    w[0] = CMD_XFER;
    i_host.xfer(1, w, 1'b1, 4);
    chk8(i_host.rd[0], XFER_RD_CNT);
    chk8(i_host.rd[1], sq[7:0]);
    chk8(i_host.rd[2], sq[15:8]);
    chk8(i_host.rd[3], s); // host inspects the status byte
    chk8(i_host.pec, 8'h00);
  endtask

  task automatic pkt(input logic [15:0] sq, input logic [31:0] d);
    w[0] = CMD_XFER;
    w[1] = 8'h06;
    {w[3], w[2]} = sq;
    {w[7], w[6], w[5], w[4]} = d;
    wr(8);
  endtask

  task automatic t_locked;
    boot(8'h70, BOOT_ENTER);
    chk8(st, ST_APP);
    chk8({7'h00, main_off}, 8'h00);
    $display("test locked finished");
  endtask

  task automatic t_enter;
    w[0] = CMD_UNLOCK;
    w[1] = UNLOCK_LEN;
    {w[2], w[3], w[4], w[5]} = UNLOCK_WORD;
    wr(6);
    chk8({7'h00, unlocked}, 8'h01);
    boot(TGT_SEC, BOOT_ENTER);
    stat(ST_BOOT_OK);
    chk8({7'h00, main_off}, 8'h01);
    $display("test enter finished");
  endtask

  task automatic t_reject;
    boot(8'h70, BOOT_ERASE);
    stat(ST_ERASED_OK);
    pkt(16'h0007, 32'h01020304);
    chk8(st, ST_ERASED_OK | 8'h04);
    rd_seq(SEQ_FIRST, ST_ERASED_OK | 8'h04);
    boot(8'h70, BOOT_EXIT);
    chk8(st, ST_ERASED_OK | 8'h04);
    chk8({7'h00, main_off}, 8'h01);
    $display("test reject finished");
  endtask

  task automatic t_good;
    boot(8'h70, BOOT_ERASE);
    stat(ST_ERASED_OK);
    ck = crc16(48'h123456789ABC);
    pkt(SEQ_FIRST, 32'h78563412);
    rd_seq(16'h0001, ST_ERASED_OK);
    pkt({i_host.rd[2], i_host.rd[1]}, {ck, 8'hBC, 8'h9A});
    rd_seq(16'h0002, ST_ERASED_OK);
    boot(8'h70, BOOT_DONE);
    stat(ST_BOOT_OK);
    boot(8'h70, BOOT_EXIT);
    stat(ST_APP);
    chk8({7'h00, main_off}, 8'h00);
    $display("test good finished");
  endtask

  task automatic t_log;
    for (int k = 1; k <= 6; k++) begin
      @(posedge CLK);
      #1;
      LOG_TRIG = 1'b1;
      LOG_SNAP = {4{8'(k * 16)}};
      @(posedge CLK);
      #1;
      LOG_TRIG = 1'b0;
      repeat (10) @(posedge CLK);
    end
    w[0] = CMD_LOG;
    i_host.xfer(1, w, 1'b1, 0);
    chk8(i_host.rd[0], LOG_LEN_MAX);
    chk8(i_host.pec, 8'h00);
    chk8(i_host.rd[1], 8'h60);
    for (int r = 1; r < 4; r++) begin
      chk8(i_host.rd[1 + 8 * r], 8'(16 * r + 16));
    end
    i_host.xfer(1, w, 1'b1, 0);
    chk8(i_host.rd[1], 8'h50);
    chk8(i_host.rd[9], 8'h00);
    SEC_DATA_OK = 1'b0;
    i_host.xfer(1, w, 1'b1, 0);
    chk8(i_host.rd[0], 8'h00);
    chk8(i_host.pec, 8'h00);
    $display("test log finished");
  endtask

  initial begin
    fails       = 0;
    compares    = 0;
    RESET_N     = 1'b0;
    LOG_TRIG    = 1'b0;
    LOG_SNAP    = 32'h00000000;
    SEC_DATA_OK = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    RESET_N = 1'b1;
    repeat (5) @(posedge CLK);
    #1;
    t_locked;
    t_enter;
    t_reject;
    t_good;
    t_log;
    report_and_stop;
  end

  // all scenarios need about 31k cycles
  initial begin
    repeat (90000) @(posedge CLK);
    fails++;
    report_and_stop;
  end
endmodule // tb_top
